//--- verilog/adcc_pkg.sv
// Constants, register map and types of the converter control block
package adcc_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [11:0] OFS_STATUS = 12'h400;
  localparam logic [11:0] OFS_CH_CFG0 = 12'h518;
  localparam logic [11:0] OFS_CH_LIM0 = 12'h51c;
  localparam logic [11:0] OFS_RES = 12'h5f0;
  localparam logic [11:0] OFS_OS = 12'h5f4;
  localparam logic [11:0] OFS_RATE = 12'h5f8;
  localparam logic [11:0] OFS_PTR = 12'h62c;
  localparam logic [11:0] OFS_WLIMIT = 12'h630;
  localparam logic [11:0] OFS_AMOUNT = 12'h634;
  localparam logic [11:0] OFS_ACT_CH = 12'h640;
  localparam logic [11:0] CH_STRIDE = 12'h010;
  localparam int NUM_CH = 8;
  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CFG_POS_LADDER_SEL_LSB = 0;
  localparam int CFG_NEG_LADDER_SEL_LSB = 4;
  localparam int CFG_GAIN_LSB = 8;
  localparam int CFG_REF_BIT = 12;
  localparam int CFG_ACQUIRE_TIME_LSB = 16;
  localparam int CFG_MODE_BIT = 20;
  localparam int CFG_BURST_BIT = 24;
  localparam int RATE_MODE_BIT = 16;
  localparam int CC_W = 11;
  localparam int CNT_W = 16;
  localparam int SAMP_W = 14;
  localparam int ACC_W = 22;
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam logic [31:0] CFG_RST = 32'h00020000;
  localparam logic [31:0] LIM_RST = 32'h7fff8000;
  localparam logic [1:0] RES_RST = 2'h1;
  localparam logic [3:0] OS_MAX = 4'h8;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int TIMER_MHZ = 16;
  localparam int ACQ_US_0 = 3;
  localparam int ACQ_US_1 = 5;
  localparam int ACQ_US_2 = 10;
  localparam int ACQ_US_3 = 15;
  localparam int ACQ_US_4 = 20;
  localparam int ACQ_US_5 = 40;
  localparam int ACQ_W = 13;
  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    LAD_BYPASS = 2'h0,
    LAD_PULLDOWN = 2'h1,
    LAD_PULLUP = 2'h2,
    LAD_HALF_SUPPLY = 2'h3
  } adcc_ladder_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACQ = 2'h1,
    ST_CONV = 2'h2,
    ST_PUSH = 2'h3
  } adcc_state_t;
endpackage : adcc_pkg

//--- verilog/adcc_ctrl.sv
// Converter control, register file, averaging and result transfer
`timescale 1ns/100ps

// ************************************************************
// Result FIFO
// ************************************************************
module adcc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt != (AW+1)'(DEPTH);
  assign out_valid = cnt != '0;
  assign out_data = mem[rp];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= push ? wp + 1'b1 : wp;
      rp <= pop ? rp + 1'b1 : rp;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : adcc_fifo

module adcc_ctrl
  import adcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic start_task,
  input wire logic sample_task,
  input wire logic stop_task,
  output logic afe_track,
  output logic afe_start,
  input wire logic conv_done,
  input wire logic [SAMP_W-1:0] conv_data,
  output logic [1:0] pos_ladder_sel,
  output logic [1:0] neg_ladder_sel,
  output logic [2:0] afe_gain,
  output logic reference_choice,
  output logic neg_to_ground,
  output logic dma_req,
  output logic [31:0] dma_addr,
  output logic [DATA_W-1:0] dma_data,
  input wire logic dma_ack,
  output logic end_event,
  output logic stopped_event,
  output logic limit_high_event,
  output logic limit_low_event,
  output logic status_busy
);
  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [ACQ_W-1:0] acq_cycles(input logic [2:0] code);
    case (code)
      3'h0: acq_cycles = ACQ_W'(ACQ_US_0 * CLK_MHZ);
      3'h1: acq_cycles = ACQ_W'(ACQ_US_1 * CLK_MHZ);
      3'h2: acq_cycles = ACQ_W'(ACQ_US_2 * CLK_MHZ);
      3'h3: acq_cycles = ACQ_W'(ACQ_US_3 * CLK_MHZ);
      3'h4: acq_cycles = ACQ_W'(ACQ_US_4 * CLK_MHZ);
      default: acq_cycles = ACQ_W'(ACQ_US_5 * CLK_MHZ);
    endcase
  endfunction : acq_cycles

  // Drops the low bits that the chosen resolution does not keep
  function automatic logic [SAMP_W-1:0] res_trim(input logic [1:0] res,
      input logic [SAMP_W-1:0] raw);
    res_trim = raw >> (4'(3 - res) << 1);
  endfunction : res_trim

  // ************************************************************
  // Registers
  // ************************************************************
  logic [31:0] ch_cfg [NUM_CH];
  logic [31:0] ch_lim [NUM_CH];
  logic [1:0] resolution;
  logic [3:0] os_code;
  logic rate_mode;
  logic [CC_W-1:0] rate_divisor;
  logic [31:0] buffer_pointer;
  logic [CNT_W-1:0] word_limit;
  logic [CNT_W-1:0] word_count;
  logic [2:0] act_ch;
  adcc_state_t state;

  wire [11:0] ch_rel = reg_addr - OFS_CH_CFG0;
  wire [2:0] ch_idx = ch_rel[6:4];
  wire ch_hit = (reg_addr >= OFS_CH_CFG0) && (ch_rel[11:7] == '0);
  wire cfg_hit = ch_hit && (ch_rel[3:0] == 4'h0);
  wire lim_hit = ch_hit && (ch_rel[3:0] == 4'h4);
  wire [31:0] cur_cfg = ch_cfg[act_ch];
  wire [31:0] cur_lim = ch_lim[act_ch];
  wire [3:0] os_eff = (os_code > OS_MAX) ? OS_MAX : os_code;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_cfg[i] <= CFG_RST;
        ch_lim[i] <= LIM_RST;
      end
      resolution <= RES_RST;
      os_code <= '0;
      rate_mode <= 1'b0;
      rate_divisor <= '0;
      buffer_pointer <= '0;
      word_limit <= '0;
      act_ch <= '0;
    end else if (reg_wr) begin
      if (cfg_hit) begin
        ch_cfg[ch_idx] <= reg_wdata;
      end
      if (lim_hit) begin
        ch_lim[ch_idx] <= reg_wdata;
      end
      case (reg_addr)
        OFS_RES: resolution <= reg_wdata[1:0];
        OFS_OS: os_code <= reg_wdata[3:0];
        OFS_RATE: begin
          rate_divisor <= reg_wdata[CC_W-1:0];
          rate_mode <= reg_wdata[RATE_MODE_BIT];
        end
        OFS_PTR: buffer_pointer <= reg_wdata;
        OFS_WLIMIT: word_limit <= reg_wdata[CNT_W-1:0];
        OFS_ACT_CH: act_ch <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (cfg_hit) begin
      rd_mux = ch_cfg[ch_idx];
    end else if (lim_hit) begin
      rd_mux = ch_lim[ch_idx];
    end else begin
      case (reg_addr)
        OFS_STATUS: rd_mux = {31'h0, state != ST_IDLE};
        OFS_RES: rd_mux = {30'h0, resolution};
        OFS_OS: rd_mux = {28'h0, os_code};
        OFS_RATE: rd_mux = {15'h0, rate_mode, 5'h0, rate_divisor};
        OFS_PTR: rd_mux = buffer_pointer;
        OFS_WLIMIT: rd_mux = {16'h0, word_limit};
        OFS_AMOUNT: rd_mux = {16'h0, word_count};
        OFS_ACT_CH: rd_mux = {29'h0, act_ch};
        default: rd_mux = '0;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // ************************************************************
  // Sample rate timer
  // ************************************************************
  // Rounded down: the timer never runs slower than asked
  wire [17:0] rate_reload =
    18'((32'(rate_divisor) * CLK_MHZ) / TIMER_MHZ);
  logic [17:0] rate_cnt;
  logic running;
  wire rate_tick = rate_mode && running && (rate_cnt == 18'h1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt <= '0;
    end else if (!rate_mode || !running || rate_cnt <= 18'h1) begin
      rate_cnt <= rate_reload;
    end else begin
      rate_cnt <= rate_cnt - 18'h1;
    end
  end
  wire trigger = running && (rate_mode ? rate_tick : sample_task);

  // ************************************************************
  // Conversion sequencer with averaging
  // ************************************************************
  logic [ACQ_W-1:0] acq_cnt;
  logic [8:0] samp_cnt;
  logic [ACC_W-1:0] acc;
  wire [8:0] samp_goal = 9'h1 << os_eff;
  wire burst = cur_cfg[CFG_BURST_BIT];
  wire [ACC_W-1:0] avg = acc >> os_eff;
  wire [DATA_W-1:0] result = DATA_W'(avg);
  wire fifo_in_ready;
  wire [ACC_W-1:0] next_acc =
    acc + ACC_W'(res_trim(resolution, conv_data));
  adcc_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = trigger ? ST_ACQ : ST_IDLE;
      ST_ACQ: next_state = (acq_cnt == ACQ_W'(1)) ? ST_CONV : ST_ACQ;
      ST_CONV: begin
        if (conv_done) begin
          if (samp_cnt + 9'h1 == samp_goal) begin
            next_state = ST_PUSH;
          end else begin
            next_state = burst ? ST_ACQ : ST_IDLE;
          end
        end
      end
      ST_PUSH: next_state = fifo_in_ready ? ST_IDLE : ST_PUSH;
      default: next_state = ST_IDLE;
    endcase
    if (stop_task) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      acq_cnt <= '0;
      samp_cnt <= '0;
      acc <= '0;
    end else begin
      state <= next_state;
      if (next_state == ST_ACQ && state != ST_ACQ) begin
        acq_cnt <= acq_cycles(cur_cfg[CFG_ACQUIRE_TIME_LSB +: 3]);
      end else if (acq_cnt != '0) begin
        acq_cnt <= acq_cnt - ACQ_W'(1);
      end
      if (stop_task || (state == ST_PUSH && fifo_in_ready)) begin
        samp_cnt <= '0;
        acc <= '0;
      end else if (state == ST_CONV && conv_done) begin
        samp_cnt <= samp_cnt + 9'h1;
        acc <= next_acc;
      end
    end
  end

  // ************************************************************
  // Front end drive and limit compare
  // ************************************************************
  wire [15:0] lim_low = cur_lim[15:0];
  wire [15:0] lim_high = cur_lim[31:16];
  wire push_now = state == ST_PUSH && fifo_in_ready;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      afe_track <= 1'b0;
      afe_start <= 1'b0;
      pos_ladder_sel <= LAD_BYPASS;
      neg_ladder_sel <= LAD_BYPASS;
      afe_gain <= '0;
      reference_choice <= 1'b0;
      neg_to_ground <= 1'b1;
      status_busy <= 1'b0;
      limit_high_event <= 1'b0;
      limit_low_event <= 1'b0;
    end else begin
      afe_track <= next_state == ST_ACQ;
      afe_start <= state == ST_ACQ && next_state == ST_CONV;
      pos_ladder_sel <= cur_cfg[CFG_POS_LADDER_SEL_LSB +: 2];
      neg_ladder_sel <= cur_cfg[CFG_NEG_LADDER_SEL_LSB +: 2];
      afe_gain <= cur_cfg[CFG_GAIN_LSB +: 3];
      reference_choice <= cur_cfg[CFG_REF_BIT];
      neg_to_ground <= !cur_cfg[CFG_MODE_BIT];
      status_busy <= next_state != ST_IDLE;
      limit_high_event <= push_now && $signed(result) > $signed(lim_high);
      limit_low_event <= push_now && $signed(result) < $signed(lim_low);
    end
  end

  // ************************************************************
  // Result FIFO and transfer to memory
  // ************************************************************
  wire fifo_out_valid;
  wire [DATA_W-1:0] fifo_out_data;
  wire at_limit = word_count >= word_limit;
  // A start or stop owns the transfer logic that cycle, so no word is popped
  wire fifo_pop = fifo_out_valid && !dma_req && running && !at_limit &&
    !start_task && !stop_task;
  adcc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(state == ST_PUSH),
    .in_ready(fifo_in_ready),
    .in_data(result),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Words are 16 bits, so the address steps by two bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      dma_req <= 1'b0;
      dma_addr <= '0;
      dma_data <= '0;
      word_count <= '0;
      end_event <= 1'b0;
      stopped_event <= 1'b0;
    end else begin
      end_event <= 1'b0;
      stopped_event <= stop_task && running;
      if (start_task) begin
        running <= 1'b1;
        word_count <= '0;
      end else if (stop_task) begin
        running <= 1'b0;
        dma_req <= 1'b0;
      end else if (dma_req && dma_ack) begin
        dma_req <= 1'b0;
        word_count <= word_count + CNT_W'(1);
        if (word_count + CNT_W'(1) == word_limit) begin
          running <= 1'b0;
          end_event <= 1'b1;
        end
      end else if (fifo_pop) begin
        dma_req <= 1'b1;
        dma_data <= fifo_out_data;
        dma_addr <= buffer_pointer + {15'h0, word_count, 1'b0};
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic [ACQ_W-1:0] trk_len;
  logic [ACQ_W-1:0] acq_goal;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trk_len <= '0;
      acq_goal <= '0;
    end else begin
      trk_len <= afe_track ? trk_len + ACQ_W'(1) : '0;
      acq_goal <= acq_cycles(cur_cfg[CFG_ACQUIRE_TIME_LSB +: 3]);
    end
  end
  sequence s_conv_end;
    state == ST_CONV && conv_done;
  endsequence
  sequence s_goal_met;
    samp_cnt + 9'h1 == samp_goal;
  endsequence

  property p_busy;
    @(posedge clk) disable iff (!rst_n)
    status_busy == (state != ST_IDLE);
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag wrong");
  property p_pos;
    @(posedge clk) disable iff (!rst_n)
    afe_start |-> pos_ladder_sel == $past(cur_cfg[1:0]);
  endproperty
  a_pos: assert property (p_pos) else $error("ladder select wrong");
  property p_gnd;
    @(posedge clk) disable iff (!rst_n)
    afe_start && !$past(cur_cfg[CFG_MODE_BIT]) |-> neg_to_ground;
  endproperty
  a_gnd: assert property (p_gnd) else $error("negative not grounded");
  property p_acq;
    @(posedge clk) disable iff (!rst_n)
    $fell(afe_track) && !$past(stop_task) |-> $past(trk_len) + ACQ_W'(1)
      == $past(acq_goal, 2);
  endproperty
  a_acq: assert property (p_acq) else $error("acquire time wrong");
  property p_burst;
    @(posedge clk) disable iff (!rst_n)
    s_conv_end and s_goal_met and !stop_task |=> state == ST_PUSH;
  endproperty
  a_burst: assert property (p_burst) else $error("average not sent");
  property p_task;
    @(posedge clk) disable iff (!rst_n)
    state == ST_IDLE && running && !rate_mode && sample_task && !stop_task
      |=> state == ST_ACQ ##1 afe_track;
  endproperty
  a_task: assert property (p_task) else $error("task ignored");
  property p_limit;
    @(posedge clk) disable iff (!rst_n)
    dma_req |-> word_count < word_limit;
  endproperty
  a_limit: assert property (p_limit) else $error("wrote past limit");
  property p_end;
    @(posedge clk) disable iff (!rst_n)
    end_event |-> word_count == word_limit && !running;
  endproperty
  a_end: assert property (p_end) else $error("word count wrong");
  property p_high;
    @(posedge clk) disable iff (!rst_n)
    limit_high_event |-> $signed($past(result)) > $signed($past(lim_high));
  endproperty
  a_high: assert property (p_high) else $error("false high event");
  property p_rate;
    @(posedge clk) disable iff (!rst_n)
    rate_tick && rate_divisor == $past(rate_divisor)
      |-> rate_reload == 18'((32'(rate_divisor) * 25) / 4);
  endproperty
  a_rate: assert property (p_rate) else $error("rate reload wrong");
endmodule : adcc_ctrl

//--- verif/adcc_far_model.sv
// Behavioural front end and result memory port facing the converter block
`timescale 1ns/100ps
module adcc_far_model
  import adcc_pkg::*;
#(
  parameter int CONV_LAT = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic afe_start,
  output logic conv_done,
  output logic [SAMP_W-1:0] conv_data,
  input wire logic [SAMP_W-1:0] conv_value,
  input wire logic dma_req,
  input wire logic [31:0] dma_addr,
  input wire logic [DATA_W-1:0] dma_data,
  output logic dma_ack,
  input wire logic [3:0] ack_delay,
  output logic [31:0] wr_count,
  output logic [31:0] last_addr,
  output logic [DATA_W-1:0] last_data
);
  int conv_cnt;
  int wait_cnt;
  // ************************************************************
  // Conversion
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      conv_cnt <= 0;
      conv_done <= 1'b0;
      conv_data <= '0;
    end else begin
      conv_done <= 1'b0;
      // Data only mean something with the done pulse, so they toggle
      conv_data <= ~conv_data;
      if (afe_start) begin
        conv_cnt <= CONV_LAT;
      end else if (conv_cnt == 1) begin
        conv_cnt <= 0;
        conv_done <= 1'b1;
        conv_data <= conv_value;
      end else if (conv_cnt > 1) begin
        conv_cnt <= conv_cnt - 1;
      end
    end
  end
  // ************************************************************
  // Memory port
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_ack <= 1'b0;
      wait_cnt <= 0;
      wr_count <= '0;
      last_addr <= '0;
      last_data <= '0;
    end else begin
      dma_ack <= 1'b0;
      if (dma_req && !dma_ack) begin
        if (wait_cnt >= int'(ack_delay)) begin
          dma_ack <= 1'b1;
          wait_cnt <= 0;
          wr_count <= wr_count + 32'h1;
          last_addr <= dma_addr;
          last_data <= dma_data;
        end else begin
          wait_cnt <= wait_cnt + 1;
        end
      end
    end
  end
endmodule : adcc_far_model

//--- verif/tb_adcc_ctrl.sv
// Self-checking bench of the converter control block
`timescale 1ns/100ps
module tb_adcc_ctrl;
  import adcc_pkg::*;
  typedef struct {
    logic [11:0] a;
    logic [31:0] w;
    logic [31:0] rst;
    logic [31:0] rb;
  } adcc_row_t;
  localparam int TIMEOUT = 40000;
  localparam logic [31:0] PTR = 32'h20000100;
  logic clk, rst_b, reg_wr, reg_rd, start_task, sample_task, stop_task;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, dma_addr, wr_count, last_addr;
  logic afe_track, afe_start, conv_done, reference_choice, neg_to_ground;
  logic dma_req, dma_ack, end_event, stopped_event, status_busy;
  logic limit_high_event, limit_low_event;
  logic [SAMP_W-1:0] conv_data, conv_value;
  logic [1:0] pos_ladder_sel, neg_ladder_sel;
  logic [2:0] afe_gain;
  logic [3:0] ack_delay;
  logic [DATA_W-1:0] dma_data, last_data;
  int err_count, checks_done, cyc, starts, ends, stops, highs, lows;
  int acq_us [6] = '{ACQ_US_0, ACQ_US_1, ACQ_US_2, ACQ_US_3, ACQ_US_4,
    ACQ_US_5};
  adcc_row_t rows [10];

  adcc_ctrl dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .start_task(start_task),
    .sample_task(sample_task), .stop_task(stop_task),
    .afe_track(afe_track), .afe_start(afe_start), .conv_done(conv_done),
    .conv_data(conv_data), .pos_ladder_sel(pos_ladder_sel),
    .neg_ladder_sel(neg_ladder_sel), .afe_gain(afe_gain),
    .reference_choice(reference_choice), .neg_to_ground(neg_to_ground),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_data(dma_data),
    .dma_ack(dma_ack), .end_event(end_event), .stopped_event(stopped_event),
    .limit_high_event(limit_high_event), .limit_low_event(limit_low_event),
    .status_busy(status_busy));
  adcc_far_model far (.clk(clk), .rst_b(rst_b), .afe_start(afe_start),
    .conv_done(conv_done), .conv_data(conv_data), .conv_value(conv_value),
    .dma_req(dma_req), .dma_addr(dma_addr), .dma_data(dma_data),
    .dma_ack(dma_ack), .ack_delay(ack_delay), .wr_count(wr_count),
    .last_addr(last_addr), .last_data(last_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ************************************************************
  // Monitors and hang guard
  // ************************************************************
  always @(posedge clk) begin
    cyc++;
    if (afe_start === 1'b1) starts++;
    if (end_event === 1'b1) ends++;
    if (stopped_event === 1'b1) stops++;
    if (limit_high_event === 1'b1) highs++;
    if (limit_low_event === 1'b1) lows++;
    if (cyc == TIMEOUT) begin
      err_count++;
      $display("BAD %0t run did not finish", $time);
      complete_run();
    end
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_cnt(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp) begin
      err_count++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_cnt
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input string what);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp, what);
  endtask : rd
  // Kind 0 starts, 1 samples, 2 stops
  task automatic pulse(input int k);
    @(posedge clk);
    start_task <= (k == 0);
    sample_task <= (k == 1);
    stop_task <= (k == 2);
    @(posedge clk);
    start_task <= 1'b0;
    sample_task <= 1'b0;
    stop_task <= 1'b0;
  endtask : pulse
  task automatic acq_len(output int n, output int t0);
    int i;
    i = 0;
    n = 0;
    while (afe_track !== 1'b1 && i < 1000) begin
      @(negedge clk);
      i++;
    end
    t0 = cyc;
    chk(status_busy, 1'b1, "busy in acquisition");
    while (afe_track === 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask : acq_len
  task automatic wait_wr(input logic [31:0] n0);
    int i;
    i = 0;
    while (wr_count === n0 && i < 2000) begin
      @(negedge clk);
      i++;
    end
    chk(wr_count, n0 + 32'h1, "one result word written");
  endtask : wait_wr
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    int n, t0, t1, s0, h0, l0;
    logic [31:0] n0, w;
    rst_b = 1'b0;
    {reg_wr, reg_rd, start_task, sample_task, stop_task} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    conv_value = 14'h2abc;
    ack_delay = 4'h0;
    rows = '{'{OFS_CH_CFG0, 32'h00141723, CFG_RST, 32'h00141723},
      '{OFS_CH_LIM0, 32'h01f400c8, LIM_RST, 32'h01f400c8},
      '{OFS_RES, 32'h3, 32'h1, 32'h3}, '{OFS_OS, 32'h8, 32'h0, 32'h8},
      '{OFS_RATE, 32'h7ff, 32'h0, 32'h7ff}, '{OFS_PTR, PTR, 32'h0, PTR},
      '{OFS_WLIMIT, 32'h4, 32'h0, 32'h4}, '{OFS_AMOUNT, 32'h1234, 0, 0},
      '{OFS_STATUS, 32'h1, 32'h0, 32'h0}, '{12'h7fc, 32'hffff, 0, 0}};
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({neg_to_ground, status_busy, dma_req}, 3'b100, "reset outs");
    $display("reset test done");
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].rst, "reset value");
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].rb, "read back");
    end
    $display("register table test done");
    for (int i = 0; i < 8; i++) begin
      w = (i % 4) | ((3 - i % 4) << 4) | (i << 8) | ((i % 2) << 12);
      wr(OFS_CH_CFG0, w | ((i % 6) << 16) | ((i % 2) << 20));
      repeat (2) @(posedge clk);
      #1;
      chk({pos_ladder_sel, neg_ladder_sel, afe_gain, reference_choice,
        neg_to_ground}, {i[1:0], ~i[1:0], i[2:0], i[0], ~i[0]},
        "front end fields");
    end
    $display("field decode test done");
    wr(OFS_RES, 32'h3);
    wr(OFS_OS, 32'h0);
    wr(OFS_RATE, 32'h0);
    wr(OFS_WLIMIT, 32'h40);
    pulse(0);
    for (int k = 0; k < 6; k++) begin
      wr(OFS_CH_CFG0, k << 16);
      n0 = wr_count;
      pulse(1);
      acq_len(n, t0);
      chk_cnt(n, acq_us[k] * CLK_MHZ, "acquire cycles");
      wait_wr(n0);
    end
    $display("acquire time test done");
    wr(OFS_CH_CFG0, 32'h0);
    ack_delay <= 4'h3;
    wr(OFS_WLIMIT, 32'h4);
    wr(OFS_PTR, PTR);
    pulse(0);
    rd(OFS_AMOUNT, 32'h0, "count cleared by start");
    s0 = ends;
    h0 = highs;
    l0 = lows;
    for (int r = 0; r < 4; r++) begin
      wr(OFS_RES, r);
      n0 = wr_count;
      pulse(1);
      wait_wr(n0);
      chk(last_addr, PTR + 2 * r, "word address");
      chk(last_data, {2'h0, conv_value} >> (6 - 2 * r), "trimmed");
    end
    repeat (4) @(posedge clk);
    chk_cnt(ends - s0, 1, "end pulse");
    chk_cnt(highs - h0, 3, "high limit events");
    chk_cnt(lows - l0, 1, "low limit events");
    n0 = wr_count;
    pulse(1);
    repeat (600) @(posedge clk);
    chk(wr_count, n0, "no write past limit");
    rd(OFS_AMOUNT, 32'h4, "words since start");
    pulse(2);
    $display("transfer limit test done");
    wr(OFS_RES, 32'h3);
    wr(OFS_OS, 32'h2);
    wr(OFS_CH_CFG0, 32'h01000000);
    pulse(0);
    s0 = starts;
    pulse(1);
    repeat (5) @(posedge clk);
    rd(OFS_STATUS, 32'h1, "status busy");
    n = 0;
    while (starts - s0 < 4 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    repeat (100) @(posedge clk);
    chk_cnt(starts - s0, 4, "burst conversions");
    chk(last_data, conv_value, "burst average");
    $display("burst test done");
    wr(OFS_OS, 32'h0);
    wr(OFS_CH_CFG0, 32'h0);
    wr(OFS_WLIMIT, 32'h40);
    pulse(0);
    repeat (20) @(posedge clk);
    n0 = wr_count;
    wr(OFS_RATE, 32'h00010050);
    acq_len(n, t0);
    acq_len(n, t1);
    chk_cnt(t1 - t0, (80 * CLK_MHZ) / TIMER_MHZ, "timer period");
    s0 = stops;
    pulse(2);
    repeat (3) @(posedge clk);
    chk_cnt(stops - s0, 1, "stop pulse");
    repeat (5) @(posedge clk);
    rd(OFS_STATUS, 32'h0, "status idle");
    rd(OFS_AMOUNT, wr_count - n0, "count after stop");
    $display("timer and stop test done");
    complete_run();
  end
endmodule : tb_adcc_ctrl
